// ===== verilog/lais_map.svh
// Register offsets, field positions and reset values of the alarm interrupt block
`ifndef LAIS_MAP_SVH
`define LAIS_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define LAIS_OFF_FLAGS0 12'h000
`define LAIS_OFF_FLAGS1 12'h004
`define LAIS_OFF_MASK0 12'h008
`define LAIS_OFF_MASK1 12'h00c
`define LAIS_OFF_EDGE 12'h010
`define LAIS_OFF_STATUS_REG_ZERO 12'h014
`define LAIS_OFF_STATUS_REG_ONE 12'h018

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LAIS_F0_AMP 7
`define LAIS_F0_TJA 6
`define LAIS_F0_RJA 5
`define LAIS_F0_TOC 4
`define LAIS_F0_TCK 3
`define LAIS_F0_TLOS 2
`define LAIS_F0_SLOS 1
`define LAIS_F0_LLOS 0
`define LAIS_F1_SAIS 7
`define LAIS_F1_LAIS 6
`define LAIS_F1_PRBS 5
`define LAIS_F1_IBA 1
`define LAIS_F1_IBD 0
`define LAIS_E_TOC 0
`define LAIS_E_TCK 1
`define LAIS_E_TLOS 2
`define LAIS_E_LOS 3
`define LAIS_E_AIS 4
`define LAIS_E_PRBS 5
`define LAIS_E_IB 6

// ---------------------------------------------------------------
// Reset values and valid bits
// ---------------------------------------------------------------
`define LAIS_RST_BYTE 8'h00
`define LAIS_VALID1 8'he3
`define LAIS_VALID_EDGE 8'h7f
`define LAIS_REG_COUNT 7

`endif

// ===== verilog/lais_pkg.sv
// Types of the alarm interrupt block
package lais_pkg;

   typedef struct packed {
      logic amp_overflow;
      logic tx_jitter_fifo;
      logic rx_jitter_fifo;
   } lais_pulse_type;

   typedef struct packed {
      logic tx_overevent_state;
      logic tx_clock_missing_state;
      logic tx_signal_loss_state;
      logic sys_signal_loss_state;
      logic line_signal_loss_state;
      logic sys_alarm_ind_state;
      logic line_alarm_ind_state;
      logic prbs_lock_state;
      logic inband_activate_state;
      logic inband_deactivate_state;
   } lais_state_type;

   typedef enum logic [1:0] {
      LAIS_HTRANS_IDLE = 2'b00,
      LAIS_HTRANS_BUSY = 2'b01,
      LAIS_HTRANS_NONSEQ = 2'b10,
      LAIS_HTRANS_SEQ = 2'b11
   } lais_htrans_type;

endpackage

// ===== verilog/lais_edge_detect.sv
// Rising or any-edge detector for a group of status bits
`timescale 1ns/1ps
`default_nettype none

module lais_edge_detect #(
   parameter int WIDTH = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] level,
   input wire logic [WIDTH-1:0] any_edge,
   output logic [WIDTH-1:0] event_hit
);

   logic [WIDTH-1:0] level_prev;

   // ------------------------------------------------------------
   // Previous-cycle copy
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_prev <= '0;
      end else begin
         level_prev <= level;
      end
   end

   assign event_hit = (level & ~level_prev) | (any_edge & (level ^ level_prev));

endmodule // lais_edge_detect
`default_nettype wire

// ===== verilog/lais_top.sv
// Alarm interrupt flags with AHB-Lite register slave
//
// What this block does
// - Set flag reports on interrupt pin
// - Flags0 bit 7 amplitude overflow
// - Flags0 bit 6 tx jitter FIFO fault
// - Flags0 bit 5 rx jitter FIFO fault
// - Tx over-event: rising or any edge
// - Tx clock missing: rising or any edge
// - Sys/line signal loss share edge select
// - Sys/line alarm share edge select
// - Pattern sync: rising or any edge
// - Inband activate: rising or any edge
// - Inband deactivate shares inband select
// - Mask bit one blocks source
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lais_map.svh"

module lais_top
   import lais_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire lais_pulse_type pulse_in,
   input wire lais_state_type state_in,
   output logic irq_n
);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] flags0;
   logic [7:0] flags1;
   logic [7:0] mask0;
   logic [7:0] mask1;
   logic [7:0] edge_select_reg;
   logic [7:0] status_reg_zero;
   logic [7:0] status_reg_one;
   logic wr_pend;
   logic [11:0] wr_addr;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   function automatic logic [7:0] lais_w1c(input logic [7:0] cur, input logic [7:0] set,
                                          input logic [7:0] clr);
      lais_w1c = (cur & ~clr) | set;
   endfunction

   wire addr_phase = hsel && hready && htrans[1];
   wire rd_req = addr_phase && !hwrite;
   wire wr_req = addr_phase && hwrite;
   wire [7:0] wbyte = hwdata[7:0];
   wire wr_f0 = wr_pend && (wr_addr == `LAIS_OFF_FLAGS0);
   wire wr_f1 = wr_pend && (wr_addr == `LAIS_OFF_FLAGS1);
   wire wr_m0 = wr_pend && (wr_addr == `LAIS_OFF_MASK0);
   wire wr_m1 = wr_pend && (wr_addr == `LAIS_OFF_MASK1);
   wire wr_es = wr_pend && (wr_addr == `LAIS_OFF_EDGE);

   // ------------------------------------------------------------
   // Event detection
   // ------------------------------------------------------------
   logic [9:0] ev;
   logic [9:0] any_edge;

   assign any_edge = {edge_select_reg[`LAIS_E_TOC],
                      edge_select_reg[`LAIS_E_TCK],
                      edge_select_reg[`LAIS_E_TLOS],
                      edge_select_reg[`LAIS_E_LOS],
                      edge_select_reg[`LAIS_E_LOS],
                      edge_select_reg[`LAIS_E_AIS],
                      edge_select_reg[`LAIS_E_AIS],
                      edge_select_reg[`LAIS_E_PRBS],
                      edge_select_reg[`LAIS_E_IB],
                      edge_select_reg[`LAIS_E_IB]};

   lais_edge_detect #(.WIDTH(10)) u_edge (
      .hclk(hclk),
      .hresetn(hresetn),
      .level(state_in),
      .any_edge(any_edge),
      .event_hit(ev)
   );

   wire [7:0] set0 = {pulse_in.amp_overflow,
                      pulse_in.tx_jitter_fifo,
                      pulse_in.rx_jitter_fifo,
                      ev[9:5]};
   wire [7:0] set1 = {ev[4:2], 3'b000, ev[1:0]};
   wire [7:0] next_flags0 = lais_w1c(flags0, set0, wr_f0 ? wbyte : 8'h00);
   wire [7:0] next_flags1 = lais_w1c(flags1, set1, wr_f1 ? wbyte : 8'h00) &
                            `LAIS_VALID1;
   wire next_irq_n = ~(|(flags0 & ~mask0) | |(flags1 & ~mask1));

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic [7:0] rd_byte;
   always_comb begin
      unique case (haddr)
         `LAIS_OFF_FLAGS0: rd_byte = flags0;
         `LAIS_OFF_FLAGS1: rd_byte = flags1;
         `LAIS_OFF_MASK0: rd_byte = mask0;
         `LAIS_OFF_MASK1: rd_byte = mask1;
         `LAIS_OFF_EDGE: rd_byte = edge_select_reg;
         `LAIS_OFF_STATUS_REG_ZERO: rd_byte = status_reg_zero;
         `LAIS_OFF_STATUS_REG_ONE: rd_byte = status_reg_one;
         default: rd_byte = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // Bus state
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend <= wr_req;
         if (addr_phase) begin
            wr_addr <= haddr;
         end
         if (rd_req) begin
            hrdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // ------------------------------------------------------------
   // Flag, mask and select registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags0 <= `LAIS_RST_BYTE;
         flags1 <= `LAIS_RST_BYTE;
         mask0 <= `LAIS_RST_BYTE;
         mask1 <= `LAIS_RST_BYTE;
         edge_select_reg <= `LAIS_RST_BYTE;
         irq_n <= 1'b1;
      end else begin
         flags0 <= next_flags0;
         flags1 <= next_flags1;
         if (wr_m0) begin
            mask0 <= wbyte;
         end
         if (wr_m1) begin
            mask1 <= wbyte & `LAIS_VALID1;
         end
         if (wr_es) begin
            edge_select_reg <= wbyte & `LAIS_VALID_EDGE;
         end
         irq_n <= next_irq_n;
      end
   end

   // ------------------------------------------------------------
   // Status mirrors
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg_zero <= 8'h00;
         status_reg_one <= 8'h00;
      end else begin
         status_reg_zero <= {3'b000, state_in[9:5]};
         status_reg_one <= {state_in[4:2], 3'b000, state_in[1:0]};
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_clear_one;
      @(posedge hclk) disable iff (!hresetn)
      (wr_f0 && wbyte[`LAIS_F0_AMP] && !set0[`LAIS_F0_AMP]) |=> !flags0[`LAIS_F0_AMP];
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

   property p_zero_keeps;
      @(posedge hclk) disable iff (!hresetn)
      (wr_f0 && !wbyte[`LAIS_F0_TJA] && flags0[`LAIS_F0_TJA]) |=> flags0[`LAIS_F0_TJA];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared");

   property p_irq;
      @(posedge hclk) disable iff (!hresetn)
      (|(flags0 & ~mask0)) |=> !irq_n;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_amp;
      @(posedge hclk) disable iff (!hresetn)
      pulse_in.amp_overflow |=> flags0[`LAIS_F0_AMP];
   endproperty
   a_amp: assert property (p_amp) else $error("amplitude flag missed");

   property p_tja;
      @(posedge hclk) disable iff (!hresetn)
      pulse_in.tx_jitter_fifo |=> flags0[`LAIS_F0_TJA];
   endproperty
   a_tja: assert property (p_tja) else $error("tx fifo flag missed");

   property p_rja;
      @(posedge hclk) disable iff (!hresetn)
      pulse_in.rx_jitter_fifo |=> flags0[`LAIS_F0_RJA];
   endproperty
   a_rja: assert property (p_rja) else $error("rx fifo flag missed");

   property p_toc;
      @(posedge hclk) disable iff (!hresetn)
      $rose(state_in.tx_overevent_state) |=> flags0[`LAIS_F0_TOC];
   endproperty
   a_toc: assert property (p_toc) else $error("over-event missed");

   property p_tck_fall;
      @(posedge hclk) disable iff (!hresetn)
      ($fell(state_in.tx_clock_missing_state) && edge_select_reg[`LAIS_E_TCK])
         |=> flags0[`LAIS_F0_TCK];
   endproperty
   a_tck_fall: assert property (p_tck_fall) else $error("clock fall missed");

   property p_los_fall;
      @(posedge hclk) disable iff (!hresetn)
      ($fell(state_in.line_signal_loss_state) && !edge_select_reg[`LAIS_E_LOS] &&
       !flags0[`LAIS_F0_LLOS]) |=> !flags0[`LAIS_F0_LLOS];
   endproperty
   a_los_fall: assert property (p_los_fall) else $error("falling edge set flag");

   property p_ais;
      @(posedge hclk) disable iff (!hresetn)
      ($changed(state_in.sys_alarm_ind_state) && edge_select_reg[`LAIS_E_AIS])
         |=> flags1[`LAIS_F1_SAIS];
   endproperty
   a_ais: assert property (p_ais) else $error("alarm edge missed");

   property p_ibd;
      @(posedge hclk) disable iff (!hresetn)
      ($fell(state_in.inband_deactivate_state) && edge_select_reg[`LAIS_E_IB])
         |=> flags1[`LAIS_F1_IBD];
   endproperty
   a_ibd: assert property (p_ibd) else $error("deactivate edge missed");

   property p_mask;
      @(posedge hclk) disable iff (!hresetn)
      (flags0 == mask0 && flags1 == 8'h00) |=> irq_n;
   endproperty
   a_mask: assert property (p_mask) else $error("masked source raised irq");

   property p_reserved;
      @(posedge hclk) disable iff (!hresetn)
      1'b1 |-> (flags1[4:2] == 3'b000);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_set_wins;
      @(posedge hclk) disable iff (!hresetn)
      (wr_f0 && wbyte[`LAIS_F0_RJA] && pulse_in.rx_jitter_fifo) |=> flags0[`LAIS_F0_RJA];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set");

endmodule // lais_top
`default_nettype wire

// ===== verif/test_line_alarm_interrupt_status.sv
// Random self-checking bench of the alarm interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "lais_map.svh"

module test_line_alarm_interrupt_status
   import lais_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hreadyout, hresp, irq_n, ap_v, ap_w, m_irq_n;
   logic [11:0] haddr, ap_a;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, s_seed, b_seed;
   lais_pulse_type pulse_in;
   lais_state_type state_in;
   logic [7:0] f0, f1, m0, m1, ed, m_rd;
   logic [9:0] prev;
   logic run = 1'b0;
   int err_total = 0;
   int cmp_count = 0;

   always #5 hclk = ~hclk;

   lais_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pulse_in(pulse_in), .state_in(state_in), .irq_n(irq_n));

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [9:0] anyedge(input logic [7:0] e);
      return {e[0], e[1], e[2], e[3], e[3], e[4], e[4], e[5], e[6], e[6]};
   endfunction

   function automatic logic [7:0] readmap(input logic [11:0] a);
      case (a)
         `LAIS_OFF_FLAGS0: return f0;
         `LAIS_OFF_FLAGS1: return f1;
         `LAIS_OFF_MASK0: return m0;
         `LAIS_OFF_MASK1: return m1;
         `LAIS_OFF_EDGE: return ed;
         `LAIS_OFF_STATUS_REG_ZERO: return {3'h0, prev[9:5]};
         `LAIS_OFF_STATUS_REG_ONE: return {prev[4:2], 3'h0, prev[1:0]};
         default: return 8'h00;
      endcase
   endfunction

   always @(posedge hclk or negedge hresetn) begin : model
      logic [9:0] ev;
      logic [7:0] c0, c1;
      if (!hresetn) begin
         {f0, f1, m0, m1, ed, m_rd} = '0;
         prev = '0;
         ap_v = 1'b0;
         m_irq_n = 1'b1;
      end else begin
         ev = (state_in & ~prev) | ((state_in ^ prev) & anyedge(ed));
         c0 = 8'h00;
         c1 = 8'h00;
         m_irq_n = ~|((f0 & ~m0) | (f1 & ~m1));
         if (hsel && hreadyout && htrans[1] && !hwrite) begin
            m_rd = readmap(haddr);
         end
         if (ap_v && ap_w) begin
            case (ap_a)
               `LAIS_OFF_FLAGS0: c0 = hwdata[7:0];
               `LAIS_OFF_FLAGS1: c1 = hwdata[7:0];
               `LAIS_OFF_MASK0: m0 = hwdata[7:0];
               `LAIS_OFF_MASK1: m1 = hwdata[7:0] & `LAIS_VALID1;
               `LAIS_OFF_EDGE: ed = hwdata[7:0] & `LAIS_VALID_EDGE;
               default: ;
            endcase
         end
         f0 = (f0 & ~c0) | {pulse_in, ev[9:5]};
         f1 = ((f1 & ~c1) | {ev[4:2], 3'h0, ev[1:0]}) & `LAIS_VALID1;
         ap_v = hsel && hreadyout && htrans[1];
         ap_a = haddr;
         ap_w = hwrite;
         prev = state_in;
      end
   end

   // ---------------------------------------------------------------
   // Compare and bus tasks
   // ---------------------------------------------------------------
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         err_total++;
         end_sim;
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= LAIS_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= LAIS_HTRANS_IDLE;
      hwdata <= {24'h00_0000, d};
      wait_ready();
      chk_bit("hresp", 1'b0, hresp);
      chk_bit("hreadyout", 1'b1, hreadyout);
      if (!w) chk_word("hrdata", {24'h00_0000, m_rd}, hrdata);
   endtask

   always @(negedge hclk) chk_bit("irq_n", m_irq_n, irq_n);

   always @(posedge hclk) begin
      if (run) begin
         s_seed = lfsr(s_seed);
         state_in <= lais_state_type'(state_in ^ (s_seed[9:0] & s_seed[21:12]));
         pulse_in <= lais_pulse_type'(s_seed[31:29] & {3{s_seed[11] & s_seed[10]}});
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = LAIS_HTRANS_IDLE;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      pulse_in = '0;
      state_in = '0;
      s_seed = 32'h007f_dfd5;
      b_seed = 32'h007f_dfd5;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 8; i++) bus(1'b0, 12'(i * 4), 8'h00);
      // Set beats clear, then masked source
      bus(1'b1, `LAIS_OFF_EDGE, 8'hff);
      pulse_in <= lais_pulse_type'(3'h4);
      bus(1'b1, `LAIS_OFF_FLAGS0, 8'hff);
      pulse_in <= lais_pulse_type'(3'h0);
      bus(1'b0, `LAIS_OFF_FLAGS0, 8'h00);
      bus(1'b1, `LAIS_OFF_MASK0, 8'hff);
      bus(1'b0, `LAIS_OFF_MASK0, 8'h00);
      bus(1'b1, `LAIS_OFF_FLAGS0, 8'h7f);
      bus(1'b0, `LAIS_OFF_FLAGS0, 8'h00);
      run <= 1'b1;
      repeat (700) begin
         b_seed = lfsr(b_seed);
         bus(b_seed[3] & b_seed[4], 12'(b_seed[2:0] * 4), b_seed[15:8]);
      end
      // Reset after the random run stops
      run <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 8; i++) bus(1'b0, 12'(i * 4), 8'h00);
      end_sim;
   end
endmodule // test_line_alarm_interrupt_status

`default_nettype wire
